/* rtl/igs_consts.svh */
`ifndef IGS_CONSTS_SVH
`define IGS_CONSTS_SVH
// ****************************************************************
// register map
// ****************************************************************
`define IGS_OFF_CTRL       4'h0
`define IGS_OFF_STAT       4'h4
`define IGS_CTRL_KEY_BIT   0
`define IGS_CTRL_CHK_BIT   1
`define IGS_CTRL_RST       2'h0
// ****************************************************************
// time base
// ****************************************************************
`define IGS_CLK_HZ         25000000
`define IGS_TICK_MS        100
`define IGS_TICK_CYC       (`IGS_CLK_HZ / 1000 * `IGS_TICK_MS)
// ****************************************************************
// supervision times, in ms, and their tick counts
// ****************************************************************
`define IGS_T_DISC_GO_MS   1000
`define IGS_T_DISC_WIN_MS  6000
`define IGS_T_DISC_ABN_MS  5900
`define IGS_T_DISC_OFF_MS  300000
`define IGS_T_DIS_GO_MS    1800000
`define IGS_T_DIS_ABN_MS   5000
`define IGS_T_DIS_OFF_MS   1800000
`define IGS_T_DIS_OK_MS    3000000
`define IGS_T_TEMP_OK_MS   360000
`define IGS_TK(ms)         (15'((ms) / `IGS_TICK_MS))
// ****************************************************************
// thresholds, counter limits and bus response codes
// ****************************************************************
`define IGS_FAN_MIN_RPM    12'd390
`define IGS_TEMP_HI        8'sd35
`define IGS_TEMP_LO        8'sd5
`define IGS_DISC_LIM_CHK   2'd1
`define IGS_DISC_LIM_NRM   2'd3
`define IGS_DIS_LIM        4'd12
`define IGS_RESP_OKAY      2'b00
`define IGS_RESP_DECERR    2'b11
`endif

/* rtl/igs_pkg.sv */
package igs_pkg;
  // ion operation: none, with a main mode, or alone
  typedef enum logic [1:0] {ION_OFF, ION_COMB, ION_INDIV} igs_mode_e;
  // generator power sequencer
  typedef enum logic [1:0] {G_IDLE, G_ON, G_REST} igs_gen_e;
  // status word as software reads it
  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0]  dis_cnt;
    logic [1:0]  disc_cnt;
    logic        blink;
    logic        disc_fault;
    logic        temp_ok;
    logic        gen_pwr;
    logic        saved;
    logic        ion_on;
    logic [1:0]  rsvd2;
    igs_mode_e   mode;
  } igs_stat_s;
endpackage

/* rtl/igs_top.sv */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "igs_consts.svh"
module igs_top #(
  parameter int unsigned TICK_CYC = `IGS_TICK_CYC
) (
  input  wire logic               MCLK,
  input  wire logic               ARST_N,
  input  wire logic               UNIT_RUN,
  input  wire logic               OFFON_STOP,
  input  wire logic               ON_TIMER,
  input  wire logic               OFF_TIMER,
  input  wire logic               FAN_RUN,
  input  wire logic [11:0]        FAN_RPM,
  input  wire logic [7:0]         INTAKE_T,
  input  wire logic               NV_ION,
  input  wire logic               GEN_ABN,
  output logic                    GEN_PWR,
  output logic                    ION_LED,
  output logic                    TIMER_BLINK,
  output logic                    FAULT_STORE,
  output logic                    FAULT_HIDDEN,
  output logic                    ION_SAVED,
  output logic                    ION_ACTIVE,
  output logic                    USER_FAN,
  output logic                    AUTO_FAN_MED,
  output logic                    BOOST_INH,
  output logic                    USER_SWING,
  output igs_pkg::igs_mode_e      ION_MODE,
  input  wire logic [3:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [3:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY
);
  import igs_pkg::*;

  // ****************************************************************
  // reset release and time base
  // ****************************************************************
  logic        rst_a_q, rst_n;
  logic [21:0] pre_q;
  logic        tick_q;

  // release through two flops so every flop leaves reset together
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  // one tick each 100 ms drives all long timers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= 22'h0;
      tick_q <= 1'b0;
    end else if (pre_q == 22'(TICK_CYC - 1)) begin
      pre_q  <= 22'h0;
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + 22'h1;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // abnormal pin synchroniser
  // ****************************************************************
  logic abn_s1_q, abn_s2_q, abn_s3_q, abn_q;

  // a level only counts once the second and third stages agree
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      abn_s1_q <= 1'b0;
      abn_s2_q <= 1'b0;
      abn_s3_q <= 1'b0;
      abn_q    <= 1'b0;
    end else begin
      abn_s1_q <= GEN_ABN;
      abn_s2_q <= abn_s1_q;
      abn_s3_q <= abn_s2_q;
      if (abn_s2_q == abn_s3_q) abn_q <= abn_s3_q;
    end
  end

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic        aw_got_q, w_got_q, chk_q, key_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  igs_stat_s   stat;

  // write side: address and data caught in either order
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 4'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `IGS_RESP_OKAY;
      chk_q         <= 1'b0;
      key_q         <= 1'b0;
    end else begin
      key_q <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q      <= 1'b1;
        aw_addr_q     <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q      <= 1'b1;
        wdata_q      <= S_AXI_WDATA;
        wstrb_q      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_got_q && w_got_q && !S_AXI_BVALID) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `IGS_RESP_OKAY;
        if (aw_addr_q == `IGS_OFF_CTRL) begin
          if (wstrb_q[0]) begin
            key_q <= wdata_q[`IGS_CTRL_KEY_BIT];
            chk_q <= wdata_q[`IGS_CTRL_CHK_BIT];
          end
        end else if (aw_addr_q != `IGS_OFF_STAT) begin
          S_AXI_BRESP <= `IGS_RESP_DECERR;
        end
      end
      // readies come back only once the answer is taken
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // read side: one read in flight, answer one cycle after address
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `IGS_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `IGS_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `IGS_OFF_CTRL: S_AXI_RDATA <= {30'h0, chk_q, 1'b0};
        `IGS_OFF_STAT: S_AXI_RDATA <= stat;
        default: begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= `IGS_RESP_DECERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************************************
  // ion operation state
  // ****************************************************************
  logic      ion_on_q, saved_q, boot_q, op_stop;
  igs_mode_e mode_q;

  assign op_stop = OFFON_STOP || OFF_TIMER;

  // stop beats off timer beats key beats on timer
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ion_on_q <= 1'b0;
      saved_q  <= 1'b0;
      boot_q   <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        ion_on_q <= NV_ION;
      end else if (OFFON_STOP) begin
        ion_on_q <= 1'b0;
      end else if (OFF_TIMER) begin
        saved_q  <= ion_on_q;
        ion_on_q <= 1'b0;
      end else if (key_q) begin
        ion_on_q <= !ion_on_q;
      end else if (ON_TIMER && !UNIT_RUN && !ion_on_q) begin
        ion_on_q <= saved_q;
      end
      // an on timer firing while running leaves all as is
    end
  end

  // the main controller decides whether a mode runs beside ion
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= ION_OFF;
    end else if (!ion_on_q) begin
      mode_q <= ION_OFF;
    end else if (UNIT_RUN) begin
      mode_q <= ION_COMB;
    end else begin
      mode_q <= ION_INDIV;
    end
  end

  // individual run hands fan and swing to the user
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      USER_FAN     <= 1'b0;
      AUTO_FAN_MED <= 1'b0;
      BOOST_INH    <= 1'b0;
      USER_SWING   <= 1'b0;
    end else begin
      USER_FAN     <= mode_q == ION_INDIV;
      AUTO_FAN_MED <= mode_q == ION_INDIV;
      BOOST_INH    <= mode_q == ION_INDIV;
      USER_SWING   <= mode_q == ION_INDIV;
    end
  end

  // ****************************************************************
  // intake temperature recovery
  // ****************************************************************
  logic        temp_in, temp_ok_q;
  logic [14:0] temp_cnt_q;

  assign temp_in = ($signed(INTAKE_T) < `IGS_TEMP_HI) &&
                   ($signed(INTAKE_T) >= `IGS_TEMP_LO);

  // out of range pauses at once, recovery needs a steady six minutes
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      temp_ok_q  <= 1'b1;
      temp_cnt_q <= 15'h0;
    end else if (!temp_in) begin
      temp_ok_q  <= 1'b0;
      temp_cnt_q <= 15'h0;
    end else if (!temp_ok_q && tick_q) begin
      if (temp_cnt_q == `IGS_TK(`IGS_T_TEMP_OK_MS) - 15'h1) begin
        temp_ok_q <= 1'b1;
      end
      temp_cnt_q <= temp_cnt_q + 15'h1;
    end
  end

  // ****************************************************************
  // generator sequencer and fault supervision
  // ****************************************************************
  logic        allow, fan_ok, disc_ev, dis_ev, fault_q;
  igs_gen_e    gen_q;
  logic [14:0] on_t_q, rest_q, abn_t_q;
  logic [1:0]  disc_cnt_q;
  logic [3:0]  dis_cnt_q;

  assign fan_ok = FAN_RUN &&
                  (mode_q == ION_INDIV || FAN_RPM >= `IGS_FAN_MIN_RPM);
  assign allow  = mode_q != ION_OFF && fan_ok && temp_in && temp_ok_q &&
                  !fault_q && !op_stop;
  // window opens 1 s after power-on; the run must reach 5.9 s inside it
  assign disc_ev = gen_q == G_ON && abn_q && !dis_ev &&
                   on_t_q < `IGS_TK(`IGS_T_DISC_GO_MS + `IGS_T_DISC_WIN_MS) &&
                   abn_t_q == `IGS_TK(`IGS_T_DISC_ABN_MS);
  assign dis_ev  = gen_q == G_ON && abn_q &&
                   on_t_q >= `IGS_TK(`IGS_T_DIS_GO_MS) &&
                   abn_t_q == `IGS_TK(`IGS_T_DIS_ABN_MS);

  // abnormal run length, restarted at each window opening
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      abn_t_q <= 15'h0;
    end else if (gen_q != G_ON || !abn_q ||
                 on_t_q < `IGS_TK(`IGS_T_DISC_GO_MS) ||
                 on_t_q == `IGS_TK(`IGS_T_DIS_GO_MS)) begin
      abn_t_q <= 15'h0;
    end else if (tick_q && abn_t_q != 15'h7fff) begin
      abn_t_q <= abn_t_q + 15'h1;
    end
  end

  // a pause drops power and restarts the power-on clock
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      gen_q   <= G_IDLE;
      GEN_PWR <= 1'b0;
      on_t_q  <= 15'h0;
      rest_q  <= 15'h0;
    end else begin
      unique case (gen_q)
        G_IDLE: begin
          on_t_q <= 15'h0;
          if (allow) begin
            gen_q   <= G_ON;
            GEN_PWR <= 1'b1;
          end
        end
        G_ON: begin
          if (disc_ev || dis_ev) begin
            gen_q   <= G_REST;
            GEN_PWR <= 1'b0;
            rest_q  <= disc_ev ? `IGS_TK(`IGS_T_DISC_OFF_MS)
                               : `IGS_TK(`IGS_T_DIS_OFF_MS);
          end else if (!allow) begin
            gen_q   <= G_IDLE;
            GEN_PWR <= 1'b0;
          end else if (tick_q && on_t_q != 15'h7fff) begin
            on_t_q <= on_t_q + 15'h1;
          end
        end
        G_REST: begin
          // the rest time runs out even if ion is paused meanwhile
          if (rest_q == 15'h0) begin
            gen_q <= G_IDLE;
          end else if (tick_q) begin
            rest_q <= rest_q - 15'h1;
          end
        end
      endcase
    end
  end

  // disconnection count and fault latch
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      disc_cnt_q  <= 2'h0;
      fault_q     <= 1'b0;
      TIMER_BLINK <= 1'b0;
      FAULT_STORE <= 1'b0;
    end else begin
      FAULT_STORE <= 1'b0;
      if (disc_ev) begin
        disc_cnt_q <= disc_cnt_q + {1'b0, disc_cnt_q != 2'h3};
        if (chk_q && disc_cnt_q + 2'h1 >= `IGS_DISC_LIM_CHK) begin
          fault_q     <= 1'b1;
          TIMER_BLINK <= 1'b1;
          FAULT_STORE <= !fault_q;
        end else if (!chk_q && disc_cnt_q + 2'h1 >= `IGS_DISC_LIM_NRM) begin
          fault_q     <= 1'b1;
          FAULT_STORE <= !fault_q;
        end
      end else if (op_stop && !chk_q) begin
        disc_cnt_q <= 2'h0;
      end
    end
  end

  // discharge count, cleared by a long healthy run or a stop
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt_q    <= 4'h0;
      FAULT_HIDDEN <= 1'b0;
    end else begin
      FAULT_HIDDEN <= 1'b0;
      if (dis_ev) begin
        dis_cnt_q <= dis_cnt_q + {3'h0, dis_cnt_q != 4'hf};
        if (dis_cnt_q >= `IGS_DIS_LIM - 4'h1) FAULT_HIDDEN <= 1'b1;
      end else if (op_stop || (gen_q == G_ON && tick_q &&
                   on_t_q == `IGS_TK(`IGS_T_DIS_OK_MS))) begin
        dis_cnt_q <= 4'h0;
      end
    end
  end

  // ****************************************************************
  // lamp, status outputs and status word
  // ****************************************************************
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ION_LED    <= 1'b0;
      ION_SAVED  <= 1'b0;
      ION_ACTIVE <= 1'b0;
      ION_MODE   <= ION_OFF;
    end else begin
      ION_LED    <= ion_on_q && !fault_q;
      ION_SAVED  <= saved_q;
      ION_ACTIVE <= ion_on_q;
      ION_MODE   <= mode_q;
    end
  end

  always_comb begin
    stat            = '0;
    stat.dis_cnt    = dis_cnt_q;
    stat.disc_cnt   = disc_cnt_q;
    stat.blink      = TIMER_BLINK;
    stat.disc_fault = fault_q;
    stat.temp_ok    = temp_ok_q;
    stat.gen_pwr    = GEN_PWR;
    stat.saved      = saved_q;
    stat.ion_on     = ion_on_q;
    stat.mode       = mode_q;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_mode_comb: assert property (@(posedge MCLK)
    disable iff (!rst_n) ion_on_q && UNIT_RUN |=> mode_q == ION_COMB)
    else $error("combined mode not entered");
  chk_mode_indiv: assert property (@(posedge MCLK)
    disable iff (!rst_n) ion_on_q && !UNIT_RUN |-> ##2 ION_MODE == ION_INDIV)
    else $error("individual mode not shown");
  chk_stop_clears: assert property (@(posedge MCLK)
    disable iff (!rst_n) OFFON_STOP && !boot_q |=> !ion_on_q ##1 !ION_ACTIVE)
    else $error("stop left ion running");
  chk_fan_pause: assert property (@(posedge MCLK)
    disable iff (!rst_n) !FAN_RUN |=> !GEN_PWR)
    else $error("generator on with fan stopped");
  chk_temp_pause: assert property (@(posedge MCLK)
    disable iff (!rst_n) !temp_in |=> !GEN_PWR [*2])
    else $error("generator on out of temperature");
  chk_rpm_gate: assert property (@(posedge MCLK) disable iff (!rst_n)
    mode_q == ION_COMB && FAN_RPM < `IGS_FAN_MIN_RPM |=> !GEN_PWR)
    else $error("generator on at low fan speed");
  chk_off_save: assert property (@(posedge MCLK) disable iff (!rst_n)
    OFF_TIMER && !OFFON_STOP && !boot_q |=> saved_q == $past(ion_on_q)
    && !ion_on_q)
    else $error("off timer did not save status");
  chk_disc_rest: assert property (@(posedge MCLK)
    disable iff (!rst_n) disc_ev |=> !GEN_PWR [*8])
    else $error("generator not rested after disconnection");
  chk_fault_lamp: assert property (@(posedge MCLK)
    disable iff (!rst_n) fault_q |=> !ION_LED)
    else $error("ion lamp on after fault");
  // a saturated count must still log each further discharge event
  chk_hidden_log: assert property (@(posedge MCLK)
    disable iff (!rst_n) dis_ev && dis_cnt_q >= `IGS_DIS_LIM - 4'h1
    |=> FAULT_HIDDEN) else $error("discharge log not stored");

  cov_comb_run: cover property (@(posedge MCLK) disable iff (!rst_n)
    mode_q == ION_COMB && GEN_PWR);
  cov_disc_ev: cover property (@(posedge MCLK) disable iff (!rst_n)
    disc_ev);
  cov_fault: cover property (@(posedge MCLK) disable iff (!rst_n)
    $rose(fault_q));
endmodule // igs_top

/* tb/igs_gen_model.sv */
`timescale 1ns/1ns
// ****************
// generator stage
// ****************
module igs_gen_model (
  input  wire logic clk,
  input  wire logic pwr,
  input  wire logic fail,
  input  wire logic slow,
  output logic      abn
);
  logic [2:0] dly_q;
  // fault only shows while powered; slow mode lags it three cycles
  always_ff @(posedge clk) begin
    dly_q <= {dly_q[1:0], fail & pwr};
    if (!pwr) begin
      abn <= (abn === 1'b0); // unpowered pin floats: never a stale level
    end else begin
      abn <= slow ? dly_q[2] : fail;
    end
  end
endmodule // igs_gen_model

/* tb/test_ion_generator_supervisor.sv */
`timescale 1ns/1ns
`include "igs_consts.svh"
module test_ion_generator_supervisor;
  import igs_pkg::*;
  localparam int TK = 10; // cycles per tick, keeps minute timers short
  logic clk = 0, rst_n = 0, run = 0, fan = 1, nv = 0, fail = 0, slow = 0;
  logic [2:0] strb = 0;
  logic [11:0] rpm = 12'd400;
  logic [7:0] temp = 8'd20;
  logic [3:0] awa = 0, ara = 0, ws = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic abn, pwr, led, blink, fst, act, sav, uf, afm, bi, usw, hid;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  igs_mode_e mode;
  logic [33:0] q[$];
  int n_checks = 0, n_mismatch = 0;
  int i;
  igs_top #(.TICK_CYC(TK)) i_dut (.MCLK(clk), .ARST_N(rst_n),
    .UNIT_RUN(run), .OFFON_STOP(strb[0]), .ON_TIMER(strb[2]),
    .OFF_TIMER(strb[1]), .FAN_RUN(fan), .FAN_RPM(rpm), .INTAKE_T(temp),
    .NV_ION(nv), .GEN_ABN(abn), .GEN_PWR(pwr), .ION_LED(led),
    .TIMER_BLINK(blink), .FAULT_STORE(fst), .FAULT_HIDDEN(hid),
    .ION_SAVED(sav), .ION_ACTIVE(act), .USER_FAN(uf), .AUTO_FAN_MED(afm),
    .BOOST_INH(bi), .USER_SWING(usw), .ION_MODE(mode),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  igs_gen_model i_gen (.clk(clk), .pwr(pwr), .fail(fail), .slow(slow),
    .abn(abn));
  // 25 MHz system clock
  always #20 clk = ~clk;
  // ****************
  // shared tasks
  // ****************
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task c1(input logic g, input logic e);
    chk({33'h0, g}, {33'h0, e});
  endtask
  task cm(input igs_mode_e e);
    chk({32'h0, mode}, {32'h0, e});
  endtask
  task hang;
    n_mismatch++;
    stop_test;
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] e);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
      if (bv && bre) begin
        bre <= 0;
        chk({32'h0, bresp}, {32'h0, e});
        // let an edge pass so the next call never re-raises bready at once
        @(posedge clk);
        return;
      end
    end
    hang;
  endtask
  // expected read answer is queued, the watcher below compares it
  task rd(input logic [3:0] a, input logic [33:0] e);
    q.push_back(e);
    ara <= a;
    arv <= 1;
    rre <= 1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv && rre) begin
        rre <= 0;
        @(posedge clk);
        return;
      end
    end
    hang;
  endtask
  task pls(input logic [2:0] s);
    strb <= s;
    @(posedge clk);
    strb <= 0;
    tk(4);
  endtask
  task wp(input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      if (pwr === v) begin
        c1(pwr, v);
        return;
      end
      @(posedge clk);
    end
    hang;
  endtask
  task key;
    wr(`IGS_OFF_CTRL, 32'h1, 4'hf, `IGS_RESP_OKAY);
    tk(4);
  endtask
  // read watcher takes the oldest note on every read answer
  always @(posedge clk) begin
    if (rv && rre) chk({rresp, rdata}, q.pop_front());
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(32'haf61));
    tk(20);
    rst_n <= 1;
    tk(5);
    c1(pwr, 0);
    cm(ION_OFF);
    rd(`IGS_OFF_STAT, 34'h80);
    rd(4'h8, {`IGS_RESP_DECERR, 32'h0});
    wr(4'hc, 32'h1, 4'hf, `IGS_RESP_DECERR);
    wr(`IGS_OFF_CTRL, 32'h1, 4'h0, `IGS_RESP_OKAY);
    tk(4);
    cm(ION_OFF);
    $display("test reset done");
    temp <= 8'($urandom_range(34, 5));
    key;
    cm(ION_INDIV);
    c1(uf & afm & bi & usw, 1);
    wp(1, 20);
    c1(led, 1);
    rd(`IGS_OFF_STAT, 34'hd2);
    fan <= 0;
    tk(4);
    c1(pwr, 0);
    fan <= 1;
    wp(1, 10);
    temp <= 8'd35;
    tk(4);
    c1(pwr, 0);
    temp <= 8'd34;
    tk(3400 * TK);
    c1(pwr, 0);
    wp(1, 300 * TK);
    temp <= 8'd5;
    tk(5);
    c1(pwr, 1);
    $display("test solo done");
    pls(3'b001);
    cm(ION_OFF);
    c1(pwr, 0);
    run <= 1;
    rpm <= 12'd389;
    key;
    cm(ION_COMB);
    tk(20);
    c1(pwr, 0);
    rpm <= 12'($urandom_range(4095, 390));
    wp(1, 10);
    pls(3'b100);
    cm(ION_COMB);
    pls(3'b010);
    cm(ION_OFF);
    c1(sav, 1);
    run <= 0;
    pls(3'b100);
    c1(act, 1);
    key;
    cm(ION_OFF);
    $display("test timers done");
    nv <= 1;
    rst_n <= 0;
    tk(20);
    rst_n <= 1;
    tk(6);
    cm(ION_INDIV);
    wr(`IGS_OFF_CTRL, 32'h2, 4'hf, `IGS_RESP_OKAY);
    rd(`IGS_OFF_CTRL, 34'h2);
    wp(1, 20);
    slow <= 1;
    fail <= 1;
    for (i = 0; i < 1000 && fst !== 1'b1; i++) @(posedge clk);
    if (fst !== 1'b1) hang;
    c1(i >= 650 && i <= 800, 1);
    tk(3);
    c1(pwr, 0);
    c1(blink, 1);
    c1(led, 0);
    c1(hid, 0);
    $display("test fault done");
    stop_test;
  end
endmodule // test_ion_generator_supervisor
